// ===== serdes_parallel_word_status_port.sv
// Contract
// - Recovered word clock is the serial bit clock divided by twenty.
// - Receive bus, error flag and valid change in step with word clock.
// - Word clock stays low throughout power-on reset.
// - Error with valid means an error inside the current frame.
// - Error without valid means carrier extension data on the bus.
// - Error pin is high impedance throughout power-on reset.
// - Valid pin is high impedance throughout power-on reset; here it stays driven for the first cycle after leaving power-down.
// - Pattern select low: shared pin carries the receive error flag.
// - Pattern select high: shared pin carries pattern check pass, high.
// - Valid stays high from first to last word of a frame.
// - Valid drops before the word clock edge after the last word.
// - Low amplitude in normal use drives valid, error and bus high; here error carries the pattern result while pattern select is high.
// - In power-down the valid pin shows signal detect, low on loss.
// - Sixteen-bit transmit word captured on each reference clock rise.
// - Receive bus is valid at the word clock rising edge.
// - Enable low powers down, leaving only signal detect running; here transmit capture also keeps running.
// - Transmit reference clock runs continuously within its range.
module serdes_parallel_word_status_port #(
  parameter int WIDTH      = serdes_port_pkg::WORD_W,
  parameter int POR_CYCLES = serdes_port_pkg::POR_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             transmit_reference_clock,
  input  wire logic [WIDTH-1:0] tx_word,
  input  wire logic             device_enable,
  input  wire logic             rx_amplitude_low,
  input  wire logic             pattern_check_select,
  input  wire logic [WIDTH-1:0] rx_dec_word,
  input  wire logic             rx_dec_valid,
  input  wire logic             rx_dec_error,
  output logic                  rx_word_clock,
  output logic      [WIDTH-1:0] rx_word_bus,
  output logic                  rx_word_bus_oe,
  output logic                  receive_error_flag,
  output logic                  receive_error_flag_oe,
  output logic                  receive_word_valid,
  output logic                  receive_word_valid_oe,
  output logic                  signal_lost_flag,
  output logic      [WIDTH-1:0] tx_word_captured,
  output logic                  tx_word_strobe
);
  import serdes_port_pkg::*;

  localparam int A_DIV = WORD_DIV;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_SYNC_W-1:0] pins_s;
  logic                  en_s;
  logic                  los_s;
  logic                  psel_s;

  bit_sync #(
    .WIDTH (PIN_SYNC_W),
    .INIT  (PIN_RESET)
  ) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({pattern_check_select, rx_amplitude_low, device_enable}),
    .q   (pins_s)
  );

  assign en_s   = pins_s[PIN_ENABLE];
  assign los_s  = pins_s[PIN_LOW_AMP];
  assign psel_s = pins_s[PIN_PSEL];

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  port_state_t       st;
  port_state_t       next_st;
  logic [POR_W-1:0]  por_cnt;
  logic              por_done;

  assign por_done = (por_cnt == POR_W'(POR_CYCLES - 1));

  always_comb begin
    next_st = st;
    case (st)
      ST_POR: begin
        if (!en_s) begin
          next_st = ST_DOWN;
        end else if (por_done) begin
          next_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_s) begin
          next_st = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (en_s) begin
          next_st = ST_POR;
        end
      end
      default: next_st = ST_POR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= ST_POR;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st != ST_POR) begin
      por_cnt <= '0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + POR_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Recovered word clock
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic             word_tick;

  // Outputs move on the falling edge, so they are steady at the rise.
  assign word_tick = (st == ST_RUN) && (div_cnt == DIV_W'(HALF_DIV - 1));

  always_ff @(posedge clk) begin
    if (rst || st != ST_RUN || div_cnt == DIV_W'(WORD_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st != ST_RUN) begin
      rx_word_clock <= 1'b0;
    end else if (div_cnt == DIV_W'(WORD_DIV - 1)) begin
      rx_word_clock <= 1'b1;
    end else if (word_tick) begin
      rx_word_clock <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Pattern checker
  // ------------------------------------------------------------
  logic check_pass;

  pattern_checker #(
    .WIDTH (WIDTH),
    .ORDER (PRBS_ORDER),
    .TAP   (PRBS_TAP)
  ) u_checker (
    .clk  (clk),
    .rst  (rst || st != ST_RUN),
    .take (word_tick),
    .word (rx_dec_word),
    .pass (check_pass)
  );

  // ------------------------------------------------------------
  // Receive outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      signal_lost_flag <= 1'b0;
    end else begin
      signal_lost_flag <= los_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st == ST_POR) begin
      rx_word_bus_oe        <= 1'b0;
      receive_error_flag_oe <= 1'b0;
      receive_word_valid_oe <= 1'b0;
    end else begin
      rx_word_bus_oe        <= (st == ST_RUN);
      receive_error_flag_oe <= (st == ST_RUN);
      receive_word_valid_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st != ST_RUN) begin
      rx_word_bus <= '0;
    end else if (word_tick) begin
      rx_word_bus <= los_s ? '1 : rx_dec_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st == ST_POR) begin
      receive_word_valid <= 1'b0;
    end else if (st == ST_DOWN) begin
      receive_word_valid <= !los_s;
    end else if (word_tick) begin
      receive_word_valid <= los_s | rx_dec_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || st != ST_RUN) begin
      receive_error_flag <= 1'b0;
    end else if (word_tick) begin
      if (psel_s) begin
        receive_error_flag <= check_pass;
      end else begin
        receive_error_flag <= los_s | rx_dec_error;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit capture on the reference clock
  // ------------------------------------------------------------
  logic             tx_rst_meta;
  logic             tx_rst;
  logic [WIDTH-1:0] tx_hold;
  logic             tx_toggle;
  logic             tx_toggle_s;
  logic             tx_toggle_seen;

  always_ff @(posedge transmit_reference_clock) begin
    tx_rst_meta <= rst;
    tx_rst      <= tx_rst_meta;
  end

  always_ff @(posedge transmit_reference_clock) begin
    if (tx_rst) begin
      tx_hold   <= '0;
      tx_toggle <= 1'b0;
    end else begin
      tx_hold   <= tx_word;
      tx_toggle <= ~tx_toggle;
    end
  end

  bit_sync #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_tx_sync (
    .clk (clk),
    .rst (rst),
    .d   (tx_toggle),
    .q   (tx_toggle_s)
  );

  // The held word changes with the toggle and is settled long before the
  // toggle clears the synchroniser, so it is read without its own stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_toggle_seen   <= 1'b0;
      tx_word_captured <= '0;
      tx_word_strobe   <= 1'b0;
    end else begin
      tx_toggle_seen <= tx_toggle_s;
      tx_word_strobe <= (tx_toggle_s != tx_toggle_seen);
      if (tx_toggle_s != tx_toggle_seen) begin
        tx_word_captured <= tx_hold;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_word_period;
    @(posedge clk) disable iff (rst)
      $rose(rx_word_clock) |-> ##A_DIV ($rose(rx_word_clock) || st != ST_RUN);
  endproperty
  a_word_period: assert property (p_word_period)
    else $error("word clock period is not twenty cycles");

  property p_clock_low_por;
    @(posedge clk) disable iff (rst)
      (st == ST_POR) ##1 (st == ST_POR) |-> !rx_word_clock;
  endproperty
  a_clock_low_por: assert property (p_clock_low_por)
    else $error("word clock high during power-on reset");

  property p_hiz_por;
    @(posedge clk) disable iff (rst)
      (st == ST_POR) ##1 (st == ST_POR)
        |-> !receive_error_flag_oe && !receive_word_valid_oe && !rx_word_bus_oe;
  endproperty
  a_hiz_por: assert property (p_hiz_por)
    else $error("receive pins driven during power-on reset");

  property p_change_at_fall;
    @(posedge clk) disable iff (rst)
      (st == ST_RUN && $past(st) == ST_RUN &&
       ($changed(rx_word_bus) || $changed(receive_word_valid))) |-> !rx_word_clock;
  endproperty
  a_change_at_fall: assert property (p_change_at_fall)
    else $error("receive outputs moved away from the falling edge");

  property p_loss_high;
    @(posedge clk) disable iff (rst)
      $past(word_tick) && $past(los_s) && st == ST_RUN
        |-> (&rx_word_bus) && receive_word_valid &&
            (receive_error_flag || $past(psel_s));
  endproperty
  a_loss_high: assert property (p_loss_high)
    else $error("loss of signal not shown as all high");

  property p_pin_error;
    @(posedge clk) disable iff (rst)
      $past(word_tick) && !$past(los_s) && !$past(psel_s) && st == ST_RUN
        |-> receive_error_flag == $past(rx_dec_error);
  endproperty
  a_pin_error: assert property (p_pin_error)
    else $error("shared pin does not carry the error flag");

  property p_pin_pass;
    @(posedge clk) disable iff (rst)
      $past(word_tick) && $past(psel_s) && st == ST_RUN
        |-> receive_error_flag == $past(check_pass);
  endproperty
  a_pin_pass: assert property (p_pin_pass)
    else $error("shared pin does not carry the pattern result");

  property p_down_detect;
    @(posedge clk) disable iff (rst)
      (st == ST_DOWN) ##1 (st == ST_DOWN)
        |-> receive_word_valid_oe && (receive_word_valid == !$past(los_s));
  endproperty
  a_down_detect: assert property (p_down_detect)
    else $error("valid pin does not follow signal detect in power-down");

  property p_valid_frame;
    @(posedge clk) disable iff (rst)
      $past(word_tick) && !$past(los_s) && st == ST_RUN
        |-> receive_word_valid == $past(rx_dec_valid);
  endproperty
  a_valid_frame: assert property (p_valid_frame)
    else $error("valid does not follow the decoded frame");

  property p_tx_strobe;
    @(posedge clk) disable iff (rst)
      tx_word_strobe |=> !tx_word_strobe [*3];
  endproperty
  a_tx_strobe: assert property (p_tx_strobe)
    else $error("transmit words arrive faster than the reference clock");

  c_loss: cover property (@(posedge clk) disable iff (rst)
    st == ST_RUN && signal_lost_flag && receive_word_valid);
  c_pattern: cover property (@(posedge clk) disable iff (rst)
    psel_s && receive_error_flag && st == ST_RUN);
  c_frame: cover property (@(posedge clk) disable iff (rst)
    $rose(receive_word_valid) && st == ST_RUN);
  c_down: cover property (@(posedge clk) disable iff (rst)
    st == ST_DOWN ##1 st == ST_POR);

endmodule : serdes_parallel_word_status_port

// ===== serdes_port_pkg.sv
package serdes_port_pkg;

  // ------------------------------------------------------------
  // Word layout and clocking
  // ------------------------------------------------------------
  localparam int WORD_W         = 16;
  localparam int WORD_DIV       = 20;
  localparam int HALF_DIV       = WORD_DIV / 2;
  localparam int DIV_W          = 5;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TX_REF_MIN_MHZ = 30;
  localparam int TX_REF_MAX_MHZ = 75;

  // ------------------------------------------------------------
  // Power-on reset and signal detect
  // ------------------------------------------------------------
  localparam int POR_TIME_NS     = 1000;
  localparam int POR_CYCLES      = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W           = 9;
  localparam int LOS_THRESHOLD_MV = 200;

  // ------------------------------------------------------------
  // Pattern checker polynomial and synchroniser
  // ------------------------------------------------------------
  localparam int PRBS_ORDER  = 7;
  localparam int PRBS_TAP    = 6;
  localparam int PIN_SYNC_W  = 3;
  localparam int PIN_ENABLE  = 0;
  localparam int PIN_LOW_AMP = 1;
  localparam int PIN_PSEL    = 2;
  localparam logic [PIN_SYNC_W-1:0] PIN_RESET = 3'h1;

  typedef enum logic [1:0] {
    ST_POR  = 2'h0,
    ST_RUN  = 2'h1,
    ST_DOWN = 2'h3
  } port_state_t;

endpackage : serdes_port_pkg

// ===== bit_sync.sv
module bit_sync #(
  parameter int                WIDTH = 1,
  parameter logic [WIDTH-1:0]  INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // The first stage feeds only the second stage.
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : bit_sync

// ===== pattern_checker.sv
module pattern_checker #(
  parameter int WIDTH = 16,
  parameter int ORDER = 7,
  parameter int TAP   = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             take,
  input  wire logic [WIDTH-1:0] word,
  output logic                  pass
);

  // Bit 0 of a word is the oldest; history holds the previous word's tail.
  logic [ORDER-1:0]       hist;
  logic [WIDTH+ORDER-1:0] v;
  logic [WIDTH-1:0]       err;

  assign v = {word, hist};

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign err[i] = v[i+ORDER] ^ v[i] ^ v[i+ORDER-TAP];
  end

  // An all-zero stream satisfies the recurrence but is not a valid pattern.
  always_ff @(posedge clk) begin
    if (rst) begin
      hist <= '0;
      pass <= 1'b0;
    end else if (take) begin
      hist <= v[WIDTH+ORDER-1:WIDTH];
      pass <= ~(|err) & (|v);
    end
  end

endmodule : pattern_checker

// ===== protocol_controller_model.sv
module protocol_controller_model (
  input  wire logic                                transmit_reference_clock,
  input  wire logic                                rx_word_clock,
  input  wire logic [serdes_port_pkg::WORD_W-1:0] rx_word_bus,
  input  wire logic                                receive_word_valid,
  input  wire logic                                receive_error_flag,
  output logic      [serdes_port_pkg::WORD_W-1:0] tx_word,
  output logic      [serdes_port_pkg::WORD_W-1:0] seen_word,
  output logic                                     seen_valid,
  output logic                                     seen_error
);
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_port_pkg::*;

  // ------------------------------------------------------------
  // Transmit side
  // ------------------------------------------------------------
  // test select low
  // The controller has no factory test select to drive, so it stays low.
  // word per edge
  // Each word changes just after an edge, so it is stable at the next one.
  initial tx_word = '0;
  always @(posedge transmit_reference_clock) begin
    tx_word <= tx_word + 16'h0001;
  end

  // ------------------------------------------------------------
  // Receive side
  // ------------------------------------------------------------
  // sample on rise
  // Idle words carry nothing, so only flagged words are kept.
  initial begin
    seen_word  = '0;
    seen_valid = 1'b0;
    seen_error = 1'b0;
  end
  always @(posedge rx_word_clock) begin
    seen_valid <= receive_word_valid;
    seen_error <= receive_error_flag;
    if (receive_word_valid || receive_error_flag) begin
      seen_word <= rx_word_bus;
    end
  end
endmodule : protocol_controller_model

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_port_pkg::*;
  localparam int POR_N = 8;
  logic              clk, rst, ref_clk, enable, amp_low, psel, dvalid, derror;
  logic [WORD_W-1:0] dword, tx_word, bus, captured, seen_word, last_cap, pw;
  logic              wclk, bus_oe, err, err_oe, valid, valid_oe, lost, strobe;
  logic              seen_valid, seen_error, pv, pe, have;
  logic [127:0]      bits;
  int                n_fail, tests_run, n_strobe;
  time               t0;

  serdes_parallel_word_status_port #(.POR_CYCLES(POR_N)) serdes_parallel_word_status_port_inst (
    .clk(clk), .rst(rst), .transmit_reference_clock(ref_clk), .tx_word(tx_word),
    .device_enable(enable), .rx_amplitude_low(amp_low), .pattern_check_select(psel),
    .rx_dec_word(dword), .rx_dec_valid(dvalid), .rx_dec_error(derror),
    .rx_word_clock(wclk), .rx_word_bus(bus), .rx_word_bus_oe(bus_oe),
    .receive_error_flag(err), .receive_error_flag_oe(err_oe), .receive_word_valid(valid),
    .receive_word_valid_oe(valid_oe), .signal_lost_flag(lost),
    .tx_word_captured(captured), .tx_word_strobe(strobe));

  protocol_controller_model protocol_controller_model_inst (
    .transmit_reference_clock(ref_clk), .rx_word_clock(wclk), .rx_word_bus(bus),
    .receive_word_valid(valid), .receive_error_flag(err), .tx_word(tx_word),
    .seen_word(seen_word), .seen_valid(seen_valid), .seen_error(seen_error));

  // ------------------------------------------------------------
  // Clocks, checks and verdict
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The reference clock is offset so its edges never line up with the core clock.
  initial begin
    ref_clk = 1'b0;
    #37;
    forever #80 ref_clk = ~ref_clk;
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
                          input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check_out(input logic [WORD_W-1:0] ew, input logic ev, input logic ee);
    chk_word(bus, ew, "bus");
    chk_bit(valid, ev, "valid");
    chk_bit(err, ee, "error pin");
    chk_bit(bus_oe & err_oe & valid_oe, 1'b1, "oe");
    if (ev || ee) chk_word(seen_word, ew, "seen");
    chk_bit(seen_valid, ev, "seen valid");
    chk_bit(seen_error, ee, "seen error");
  endtask : check_out

  // Checks the word of the last period, then queues the next back to back.
  task automatic step(input logic [WORD_W-1:0] w, input logic v, input logic e);
    @(posedge wclk);
    #1;
    if (have) check_out(pw, pv, pe);
    @(posedge clk);
    dword  <= w;
    dvalid <= v;
    derror <= e;
    pw     = w;
    pv     = v;
    pe     = e;
    have   = 1'b1;
  endtask : step

  // Captured words must arrive in order, one per reference edge.
  always @(negedge clk) begin
    if (strobe === 1'b1) begin
      if (n_strobe > 2) chk_word(captured, last_cap + 16'h0001, "tx word");
      last_cap = captured;
      n_strobe++;
    end
  end

  initial begin
    #100000;
    n_fail++;
    $display("[ERR] t=%0t watchdog expired", $time);
    stop_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1; enable = 1'b1; amp_low = 1'b0; psel = 1'b0;
    dword = '0; dvalid = 1'b0; derror = 1'b0; have = 1'b0;
    for (int i = 0; i < 128; i++) bits[i] = (i < 7) ? ((7'h53 >> i) & 1) : bits[i-7] ^ bits[i-6];
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (POR_N) begin
      @(posedge clk);
      #1;
      chk_bit(wclk | err_oe | valid_oe | bus_oe, 1'b0, "power-on state");
    end
    $display("test power-on done");

    @(posedge wclk);
    t0 = $time;
    @(negedge wclk);
    chk_bit($time - t0 == 40, 1'b1, "word clock high time");
    @(posedge wclk);
    chk_bit($time - t0 == 80, 1'b1, "word clock period");
    $display("test word clock done");

    step(16'h1111, 1'b1, 1'b0);
    step(16'h2222, 1'b1, 1'b1);
    step(16'h3333, 1'b1, 1'b0);
    step(16'h0000, 1'b0, 1'b0);
    step(16'hF7F7, 1'b0, 1'b1);
    step(16'h0000, 1'b0, 1'b0);
    step(16'h0000, 1'b0, 1'b0);
    have = 1'b0;
    $display("test frame done");

    @(posedge clk);
    amp_low <= 1'b1;
    // Words taken while the loss is up are all ones, so none is checked as sent.
    repeat (2) @(posedge wclk);
    @(posedge wclk);
    #1;
    check_out(16'hFFFF, 1'b1, 1'b1);
    chk_bit(lost, 1'b1, "lost");
    @(posedge clk);
    amp_low <= 1'b0;
    $display("test loss done");

    @(posedge clk);
    psel <= 1'b1;
    // The shared pin shows the pattern result here, so the error check is skipped.
    for (int k = 0; k < 8; k++) begin
      step(bits[16*k +: 16], 1'b1, 1'b0);
      have = 1'b0;
    end
    @(posedge wclk);
    #1;
    chk_bit(err, 1'b1, "pattern pass");
    for (int k = 0; k < 3; k++) begin
      step(16'h0000, 1'b1, 1'b0);
      have = 1'b0;
    end
    @(posedge wclk);
    #1;
    chk_bit(err, 1'b0, "pattern fail");
    @(posedge clk);
    psel <= 1'b0;
    have = 1'b0;
    $display("test pattern done");

    @(posedge clk);
    enable  <= 1'b0;
    amp_low <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk_bit(valid_oe & ~valid, 1'b1, "power-down loss");
    chk_bit(wclk | bus_oe | err_oe, 1'b0, "power-down");
    @(posedge clk);
    amp_low <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk_bit(valid, 1'b1, "power-down signal");
    @(posedge clk);
    enable <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(wclk | valid_oe | err_oe, 1'b0, "reentry");
    step(16'hA5A5, 1'b1, 1'b0);
    step(16'h0000, 1'b0, 1'b0);
    step(16'h0000, 1'b0, 1'b0);
    $display("test power-down done");

    chk_bit(n_strobe > 10, 1'b1, "tx strobes");
    stop_test();
  end
endmodule : testbench
